//--- core/dmseq_regs.svh
// register offsets, field layout and timing constants of the mode sequencer
// assumes inclusion by every design file that decodes registers or counts time
`ifndef DMSEQ_REGS_SVH
`define DMSEQ_REGS_SVH

`define DMSEQ_ADDR_W 4
`define DMSEQ_REG_MODE 4'h0
`define DMSEQ_REG_TONE_LO 4'h1
`define DMSEQ_REG_TONE_HI 4'h2
`define DMSEQ_REG_F1_LO 4'h3
`define DMSEQ_REG_F1_HI 4'h4
`define DMSEQ_REG_F2_LO 4'h5
`define DMSEQ_REG_F2_HI 4'h6
`define DMSEQ_REG_STEP_LO 4'h7
`define DMSEQ_REG_STEP_HI 4'h8
`define DMSEQ_REG_DWELL 4'h9
`define DMSEQ_REG_REPEAT 4'ha
`define DMSEQ_REG_PHASE 4'hb
`define DMSEQ_REG_RAW 4'hc
`define DMSEQ_REG_STATUS 4'hd
`define DMSEQ_REG_RAWDATA 4'he
`define DMSEQ_REG_ID 4'hf

`define DMSEQ_MODE_LSB 0
`define DMSEQ_MODE_MSB 2
`define DMSEQ_RAW_BIT 8
`define DMSEQ_HI_W 16
`define DMSEQ_DWELL_W 20
`define DMSEQ_PHASE_W 16
`define DMSEQ_TRIG_HIGH_CYC 8
`define DMSEQ_TRIG_CNT_W 4
`define DMSEQ_ID_VALUE 32'h0000_5a31
`define DMSEQ_ZERO32 32'h0000_0000

`endif

//--- core/dmseq_pkg.sv
// types shared by the mode sequencer files
// assumes dmseq_regs.svh supplies the numeric constants
package dmseq_pkg;
  typedef enum logic [2:0] {
    DMSEQ_TONE = 3'h0,
    DMSEQ_FSK = 3'h1,
    DMSEQ_RAMP = 3'h2,
    DMSEQ_CHIRP = 3'h3,
    DMSEQ_BPSK = 3'h4
  } dmseq_mode_e;

  typedef enum logic [1:0] {
    DMSEQ_ST_UP = 2'b00,
    DMSEQ_ST_DOWN = 2'b01,
    DMSEQ_ST_HOLD = 2'b11
  } dmseq_state_e;

  typedef struct packed {
    logic [47:0] tuneWord;
    logic [15:0] phaseWord;
  } dmseq_out_s;

  typedef struct packed {
    logic [47:0] singleToneFreq;
    logic [47:0] firstFreq;
    logic [47:0] secondFreq;
    logic [47:0] stepIncrement;
    logic [19:0] dwellCount;
    logic [31:0] repeatCount;
    logic [15:0] firstPhase;
    logic [15:0] secondPhase;
  } dmseq_param_s;
endpackage

//--- core/dmseq_trigger.sv
// repeat-period counter and trigger pulse generator
// assumes sys_clk domain, restart pulse from the register file
`timescale 1ns/1ns
`include "dmseq_regs.svh"
module dmseq_trigger
  import dmseq_pkg::*;
#(
  parameter int REP_W = 32
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire logic restart,
  input wire logic chirpMode,
  input wire logic [REP_W-1:0] repeatCount,
  output logic periodEnd,
  output logic triggerOutput
);
  // period is 2*(repeatCount+1) cycles: a half-rate prescale plus a count
  logic halfPhase_r;
  logic [REP_W-1:0] repCnt_r;
  logic [`DMSEQ_TRIG_CNT_W-1:0] pulseCnt_r;
  wire logic repDone = halfPhase_r && (repCnt_r == repeatCount);

  assign periodEnd = repDone;
  assign triggerOutput = (pulseCnt_r != '0);

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      halfPhase_r <= 1'b0;
      repCnt_r <= '0;
      pulseCnt_r <= '0;
    end else if (clkEn) begin
      if (restart) begin
        halfPhase_r <= 1'b0;
        repCnt_r <= '0;
        pulseCnt_r <= '0;
      end else begin
        halfPhase_r <= !halfPhase_r;
        // free-running: never resynchronised to the step timing
        if (repDone) repCnt_r <= '0;
        else if (halfPhase_r) repCnt_r <= repCnt_r + 1'b1;
        if (repDone) pulseCnt_r <= `DMSEQ_TRIG_CNT_W'(`DMSEQ_TRIG_HIGH_CYC);
        else if (pulseCnt_r != '0) pulseCnt_r <= pulseCnt_r - 1'b1;
      end
    end
  end

  logic [REP_W:0] gapCnt_r;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) gapCnt_r <= '0;
    else if (clkEn) gapCnt_r <= (restart || repDone) ? '0 : gapCnt_r + 1'b1;
  end

  // a new load clears the pulse on purpose, so a restart abandons the check
  AST_PULSE_WIDTH: assert property (@(posedge sys_clk) disable iff (!reset_n || restart)
    (clkEn && !restart && repDone && repeatCount >= 32'd5) |=> triggerOutput [*8])
    else $error("trigger pulse shorter than eight cycles");
  AST_PERIOD_LEN: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (repDone && clkEn && !restart) |-> (gapCnt_r == {repeatCount, 1'b1}))
    else $error("repeat period length wrong");
endmodule

//--- core/dmseq_phase_acc.sv
// phase accumulator with phase offset, the synthesizer core model
// assumes tuning and phase words change only on clock edges
`timescale 1ns/1ns
module dmseq_phase_acc
  import dmseq_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire dmseq_out_s ctrl,
  output logic [15:0] phaseOut
);
  logic [47:0] acc_r;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) acc_r <= '0;
    else if (clkEn) acc_r <= acc_r + ctrl.tuneWord;
  end
  // accumulator never restarts on a word change, so keying is phase continuous
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) phaseOut <= '0;
    else if (clkEn) phaseOut <= acc_r[47:32] + ctrl.phaseWord;
  end
  AST_PHASE_CONT: assert property (@(posedge sys_clk) disable iff (!reset_n)
    clkEn |=> (acc_r == $past(acc_r) + $past(ctrl.tuneWord)) || !$past(clkEn))
    else $error("accumulator jumped on word change");
endmodule

//--- core/dmseq_top.sv
// mode sequencer: register file, mode sweep logic, trigger and accumulator
// assumes a plain register port in the sys_clk domain, select pin synchronous
// Contract
// - single-tone mode outputs the single-tone frequency word alone.
// - frequency-shift mode: select high gives second, low gives first frequency.
// - keyed frequency changes keep the accumulator running; select toggles up to 15MHz.
// - undriven select reads high, choosing second frequency or phase.
// - ramped mode steps first to second and back by step increment per dwell.
// - trigger period counter runs independently of frequency step timing.
// - in ramped mode repeat count affects only the trigger timing.
// - chirp mode: sawtooth from first frequency adding step per dwell.
// - chirp returns to first frequency every 2*(repeat count+1) cycles.
// - trigger pin pulses once per repeat period, high eight cycles; stays high throughout for repeat count 3 or less.
// - step increment accepted at one microhertz per unit.
// - chirp sweep ends only on repeat expiry, possibly early or overshooting.
// - phase-shift mode holds first frequency; select picks second or first phase.
// - output starts right after parameters load, no start action.
// - raw access path sets the whole 48-bit tuning word but only the low 8 bits of the phase word.
// - output frequency is a 48-bit tuning word into the accumulator.
`timescale 1ns/1ns
`include "dmseq_regs.svh"
module dmseq_top
  import dmseq_pkg::*;
#(
  parameter int FREQ_W = 48,
  parameter int REP_W = 32
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire logic [`DMSEQ_ADDR_W-1:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [31:0] regRdData,
  input wire logic keySelectIn,
  input wire logic keySelectDriven,
  output logic triggerOutput,
  output logic triggerOutEn,
  output dmseq_out_s coreCtrl,
  output logic [15:0] phaseOut
);
  function automatic logic [FREQ_W-1:0] joinWord(input logic [31:0] lo, input logic [15:0] hi);
    joinWord = {hi, lo};
  endfunction

  // parameter registers
  logic [2:0] mode_r;
  logic rawEn_r;
  logic [31:0] toneLo_r, f1Lo_r, f2Lo_r, stepLo_r;
  logic [15:0] toneHi_r, f1Hi_r, f2Hi_r, stepHi_r;
  logic [`DMSEQ_DWELL_W-1:0] dwell_r;
  logic [REP_W-1:0] repeat_r;
  logic [31:0] phase_r;
  logic [31:0] rawLo_r;
  logic [15:0] rawHi_r;
  logic [15:0] rawPhase_r;
  logic loadPulse_r;

  dmseq_param_s prm;
  assign prm.singleToneFreq = joinWord(toneLo_r, toneHi_r);
  assign prm.firstFreq = joinWord(f1Lo_r, f1Hi_r);
  assign prm.secondFreq = joinWord(f2Lo_r, f2Hi_r);
  assign prm.stepIncrement = joinWord(stepLo_r, stepHi_r);
  assign prm.dwellCount = dwell_r;
  assign prm.repeatCount = repeat_r;
  assign prm.firstPhase = phase_r[15:0];
  assign prm.secondPhase = phase_r[31:16];

  // write decode
  wire logic wrMode = regWrEn && (regAddr == `DMSEQ_REG_MODE);
  wire logic wrTLo = regWrEn && (regAddr == `DMSEQ_REG_TONE_LO);
  wire logic wrTHi = regWrEn && (regAddr == `DMSEQ_REG_TONE_HI);
  wire logic wrF1Lo = regWrEn && (regAddr == `DMSEQ_REG_F1_LO);
  wire logic wrF1Hi = regWrEn && (regAddr == `DMSEQ_REG_F1_HI);
  wire logic wrF2Lo = regWrEn && (regAddr == `DMSEQ_REG_F2_LO);
  wire logic wrF2Hi = regWrEn && (regAddr == `DMSEQ_REG_F2_HI);
  wire logic wrSLo = regWrEn && (regAddr == `DMSEQ_REG_STEP_LO);
  wire logic wrSHi = regWrEn && (regAddr == `DMSEQ_REG_STEP_HI);
  wire logic wrDwell = regWrEn && (regAddr == `DMSEQ_REG_DWELL);
  wire logic wrRep = regWrEn && (regAddr == `DMSEQ_REG_REPEAT);
  wire logic wrPhase = regWrEn && (regAddr == `DMSEQ_REG_PHASE);
  wire logic wrRaw = regWrEn && (regAddr == `DMSEQ_REG_RAW);
  wire logic wrRawData = regWrEn && (regAddr == `DMSEQ_REG_RAWDATA);
  // any parameter write restarts the sequence, so no start command is needed
  wire logic anyLoad = regWrEn && (regAddr <= `DMSEQ_REG_PHASE);

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_r <= '0;
      rawEn_r <= 1'b0;
      toneLo_r <= '0;
      toneHi_r <= '0;
      f1Lo_r <= '0;
      f1Hi_r <= '0;
      f2Lo_r <= '0;
      f2Hi_r <= '0;
      stepLo_r <= '0;
      stepHi_r <= '0;
      dwell_r <= '0;
      repeat_r <= '0;
      phase_r <= '0;
      loadPulse_r <= 1'b0;
    end else if (clkEn) begin
      if (wrMode) mode_r <= regWrData[`DMSEQ_MODE_MSB:`DMSEQ_MODE_LSB];
      if (wrTLo) toneLo_r <= regWrData;
      if (wrTHi) toneHi_r <= regWrData[`DMSEQ_HI_W-1:0];
      if (wrF1Lo) f1Lo_r <= regWrData;
      if (wrF1Hi) f1Hi_r <= regWrData[`DMSEQ_HI_W-1:0];
      if (wrF2Lo) f2Lo_r <= regWrData;
      if (wrF2Hi) f2Hi_r <= regWrData[`DMSEQ_HI_W-1:0];
      if (wrSLo) stepLo_r <= regWrData;
      if (wrSHi) stepHi_r <= regWrData[`DMSEQ_HI_W-1:0];
      if (wrDwell) dwell_r <= regWrData[`DMSEQ_DWELL_W-1:0];
      if (wrRep) repeat_r <= regWrData[REP_W-1:0];
      if (wrPhase) phase_r <= regWrData;
      if (wrRaw) rawEn_r <= regWrData[`DMSEQ_RAW_BIT];
      loadPulse_r <= anyLoad;
    end
  end

  // raw path: software writes the core words directly
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rawLo_r <= '0;
      rawHi_r <= '0;
      rawPhase_r <= '0;
    end else if (clkEn) begin
      if (wrRawData) rawLo_r <= regWrData;
      if (wrRaw) begin
        rawHi_r <= regWrData[31:16];
        rawPhase_r <= {8'h00, regWrData[7:0]};
      end
    end
  end

  // select pin: an open input is pulled to the high level
  wire logic keySel = keySelectDriven ? keySelectIn : 1'b1;

  // sweep engine
  dmseq_state_e state_r, state_nxt;
  logic [FREQ_W-1:0] sweep_r, sweep_nxt;
  logic [`DMSEQ_DWELL_W-1:0] dwellCnt_r;
  logic periodEnd;
  wire logic dwellDone = (dwellCnt_r == prm.dwellCount);
  wire logic isRamp = (mode_r == DMSEQ_RAMP);
  wire logic isChirp = (mode_r == DMSEQ_CHIRP);
  wire logic [FREQ_W-1:0] upVal = FREQ_W'(sweep_r + prm.stepIncrement);
  wire logic [FREQ_W-1:0] dnVal = FREQ_W'(sweep_r - prm.stepIncrement);
  wire logic upHits = (upVal >= prm.secondFreq) || (upVal < sweep_r);
  wire logic dnHits = (dnVal <= prm.firstFreq) || (dnVal > sweep_r);

  always_comb begin
    state_nxt = state_r;
    sweep_nxt = sweep_r;
    if (isChirp && periodEnd) begin
      sweep_nxt = prm.firstFreq;
      state_nxt = DMSEQ_ST_UP;
    end else if (dwellDone) begin
      case (state_r)
        DMSEQ_ST_UP: begin
          if (isChirp) begin
            sweep_nxt = upVal;
          end else if (upHits) begin
            sweep_nxt = prm.secondFreq;
            state_nxt = DMSEQ_ST_DOWN;
          end else begin
            sweep_nxt = upVal;
          end
        end
        DMSEQ_ST_DOWN: begin
          if (dnHits) begin
            sweep_nxt = prm.firstFreq;
            state_nxt = DMSEQ_ST_UP;
          end else begin
            sweep_nxt = dnVal;
          end
        end
        default: state_nxt = DMSEQ_ST_UP;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= DMSEQ_ST_UP;
      sweep_r <= '0;
      dwellCnt_r <= '0;
    end else if (clkEn) begin
      if (loadPulse_r || !(isRamp || isChirp)) begin
        state_r <= DMSEQ_ST_UP;
        sweep_r <= prm.firstFreq;
        dwellCnt_r <= '0;
      end else begin
        // ramp timing ignores the repeat counter entirely
        state_r <= state_nxt;
        sweep_r <= sweep_nxt;
        dwellCnt_r <= (dwellDone || (isChirp && periodEnd)) ? '0 : dwellCnt_r + 1'b1;
      end
    end
  end

  dmseq_trigger #(.REP_W(REP_W)) uTrig (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .clkEn(clkEn),
    .restart(loadPulse_r),
    .chirpMode(isChirp),
    .repeatCount(prm.repeatCount),
    .periodEnd(periodEnd),
    .triggerOutput(triggerOutput)
  );
  assign triggerOutEn = 1'b1;

  // output word selection
  logic [FREQ_W-1:0] tuneSel;
  logic [15:0] phaseSel;
  always_comb begin
    tuneSel = prm.singleToneFreq;
    phaseSel = 16'h0000;
    case (mode_r)
      DMSEQ_FSK: tuneSel = keySel ? prm.secondFreq : prm.firstFreq;
      DMSEQ_RAMP, DMSEQ_CHIRP: tuneSel = sweep_r;
      DMSEQ_BPSK: begin
        tuneSel = prm.firstFreq;
        phaseSel = keySel ? prm.secondPhase : prm.firstPhase;
      end
      default: tuneSel = prm.singleToneFreq;
    endcase
  end

  // registered so each select toggle lands on one clock edge
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) coreCtrl <= '0;
    else if (clkEn) begin
      coreCtrl.tuneWord <= rawEn_r ? {rawHi_r, rawLo_r} : tuneSel;
      coreCtrl.phaseWord <= rawEn_r ? rawPhase_r : phaseSel;
    end
  end

  dmseq_phase_acc uAcc (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .clkEn(clkEn),
    .ctrl(coreCtrl),
    .phaseOut(phaseOut)
  );

  // read path, data stand one cycle after the strobe
  wire logic [31:0] statusWord = {28'h0000000, triggerOutput, state_r, rawEn_r};
  logic [31:0] rdMux;
  always_comb begin
    if (regAddr == `DMSEQ_REG_MODE) rdMux = {29'h0, mode_r};
    else if (regAddr == `DMSEQ_REG_F1_LO) rdMux = f1Lo_r;
    else if (regAddr == `DMSEQ_REG_F1_HI) rdMux = {16'h0, f1Hi_r};
    else if (regAddr == `DMSEQ_REG_F2_LO) rdMux = f2Lo_r;
    else if (regAddr == `DMSEQ_REG_F2_HI) rdMux = {16'h0, f2Hi_r};
    else if (regAddr == `DMSEQ_REG_TONE_LO) rdMux = toneLo_r;
    else if (regAddr == `DMSEQ_REG_TONE_HI) rdMux = {16'h0, toneHi_r};
    else if (regAddr == `DMSEQ_REG_DWELL) rdMux = {12'h0, dwell_r};
    else if (regAddr == `DMSEQ_REG_REPEAT) rdMux = repeat_r;
    else if (regAddr == `DMSEQ_REG_PHASE) rdMux = phase_r;
    else if (regAddr == `DMSEQ_REG_STATUS) rdMux = statusWord;
    else if (regAddr == `DMSEQ_REG_ID) rdMux = `DMSEQ_ID_VALUE; // arbitrary value
    else rdMux = `DMSEQ_ZERO32;
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) regRdData <= '0;
    else if (clkEn) regRdData <= regRdEn ? rdMux : `DMSEQ_ZERO32;
  end

  sequence sFskHigh;
    (mode_r == DMSEQ_FSK) && !rawEn_r && keySel;
  endsequence
  AST_FSK_SECOND: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (sFskHigh and clkEn) |=> (coreCtrl.tuneWord == $past(prm.secondFreq)))
    else $error("fsk high did not select second frequency");
  AST_FSK_FIRST: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (clkEn && mode_r == DMSEQ_FSK && !rawEn_r && !keySel)
    |=> (coreCtrl.tuneWord == $past(prm.firstFreq)))
    else $error("fsk low did not select first frequency");
  AST_UNDRIVEN_HIGH: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !keySelectDriven |-> keySel)
    else $error("undriven select not high");
  AST_TONE: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (clkEn && mode_r == DMSEQ_TONE && !rawEn_r)
    |=> (coreCtrl.tuneWord == $past(prm.singleToneFreq)) && (coreCtrl.phaseWord == 16'h0))
    else $error("single tone word wrong");
  AST_BPSK: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (clkEn && mode_r == DMSEQ_BPSK && !rawEn_r)
    |=> (coreCtrl.tuneWord == $past(prm.firstFreq))
    && (coreCtrl.phaseWord == ($past(keySel) ? $past(prm.secondPhase) : $past(prm.firstPhase))))
    else $error("bpsk words wrong");
  AST_RESTART: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (clkEn && loadPulse_r) |=> (sweep_r == $past(prm.firstFreq)) && (dwellCnt_r == '0))
    else $error("load did not restart sweep");
  AST_DWELL_HOLD: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (clkEn && isRamp && !loadPulse_r && !dwellDone) |=> (sweep_r == $past(sweep_r)))
    else $error("sweep moved inside dwell");
  AST_CHIRP_WRAP: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (clkEn && isChirp && !loadPulse_r && periodEnd) |=> (sweep_r == $past(prm.firstFreq)))
    else $error("chirp did not return to first frequency");
endmodule

//--- test/dmseq_key_model.sv
// keying partner: drives the select pin the way external keying logic would
// assumes keyCmd comes from the bench and changes just after a clock edge
`timescale 1ns/1ns
module dmseq_key_model (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [1:0] keyCmd,
  output logic keySelectIn,
  output logic keySelectDriven
);
  // 0 hold low, 1 hold high, 2 released, 3 toggle every cycle
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      keySelectIn <= 1'b1;
      keySelectDriven <= 1'b0;
    end else begin
      keySelectDriven <= (keyCmd != 2'h2);
      case (keyCmd)
        2'h0: keySelectIn <= 1'b0;
        2'h1: keySelectIn <= 1'b1;
        // released pin sits at the pull-up level
        2'h2: keySelectIn <= 1'b1;
        default: keySelectIn <= ~keySelectIn;
      endcase
    end
  end
endmodule

//--- test/dmseq_top_test.sv
// self-checking bench for the mode sequencer top
// assumes the design files under core/ and the keying model under test/
`timescale 1ns/1ns
`include "dmseq_regs.svh"
module dmseq_top_test
  import dmseq_pkg::*;
;
  localparam logic [47:0] F1 = 48'h0000_0001_0000;
  localparam logic [47:0] F2 = 48'h0000_0003_0000;
  localparam logic [47:0] RF1 = 48'h0000_0010_0000;
  localparam logic [47:0] RSTEP = 48'h0000_0000_0100;
  localparam logic [47:0] CF1 = 48'h0000_0020_0000;
  localparam logic [47:0] CSTEP = 48'h0000_0000_0040;
  logic sys_clk, reset_n, clkEn, regWrEn, regRdEn;
  logic [`DMSEQ_ADDR_W-1:0] regAddr;
  logic [31:0] regWrData, regRdData;
  logic keySelectIn, keySelectDriven, triggerOutput, triggerOutEn;
  logic [1:0] keyCmd;
  logic [15:0] phaseOut;
  dmseq_out_s coreCtrl;
  int failures = 0;
  int cmp_count = 0;

  dmseq_top dmseq_top_i (.sys_clk(sys_clk), .reset_n(reset_n), .clkEn(clkEn),
    .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regRdData(regRdData), .keySelectIn(keySelectIn), .keySelectDriven(keySelectDriven),
    .triggerOutput(triggerOutput), .triggerOutEn(triggerOutEn), .coreCtrl(coreCtrl),
    .phaseOut(phaseOut));
  dmseq_key_model dmseq_key_model_i (.sys_clk(sys_clk), .reset_n(reset_n), .keyCmd(keyCmd),
    .keySelectIn(keySelectIn), .keySelectDriven(keySelectDriven));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk_word(input string what, input logic [47:0] exp, input logic [47:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic chk_flag(input string what, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %b, seen %b", what, exp, got);
    end
  endtask

  // samples land 1 ns after the edge so the edge's updates have settled
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // the trailing idle edge keeps two strobes from being set in one time step
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge sys_clk);
    regWrEn <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge sys_clk);
    regRdEn <= 1'b0;
    #1 d = regRdData;
    @(posedge sys_clk);
  endtask

  task automatic set_pair(input logic [3:0] lo, input logic [47:0] v);
    reg_wr(lo, v[31:0]);
    reg_wr(lo + 4'h1, {16'h0000, v[47:32]});
  endtask

  task automatic key_case(input logic [1:0] c, input logic [47:0] et, input logic [15:0] ep,
                          input logic withPhase);
    keyCmd <= c;
    tick(3);
    chk_word("keyed tuning word", et, coreCtrl.tuneWord);
    if (withPhase) begin
      chk_word("keyed phase word", {32'h0, ep}, {32'h0, coreCtrl.phaseWord});
    end
  endtask

  function automatic logic [47:0] tri_pos(input int k);
    int m;
    m = k % 6;
    return (m <= 3) ? 48'(m) : 48'(6 - m);
  endfunction

  task automatic test_regs();
    logic [31:0] d;
    reg_wr(`DMSEQ_REG_DWELL, 32'h000f_ffff);
    reg_rd(`DMSEQ_REG_DWELL, d);
    chk_word("dwell readback", 48'h0000_000f_ffff, {16'h0, d});
    #1 chk_word("idle read data", 48'h0, {16'h0, regRdData});
    reg_wr(`DMSEQ_REG_ID, 32'hffff_ffff);
    reg_rd(`DMSEQ_REG_ID, d);
    chk_word("id register", {16'h0, `DMSEQ_ID_VALUE}, {16'h0, d});
    reg_wr(`DMSEQ_REG_RAWDATA, 32'h0bad_cafe);
    reg_wr(`DMSEQ_REG_RAW, 32'h7e57_0112);
    reg_rd(`DMSEQ_REG_STATUS, d);
    chk_flag("raw enable status", 1'b1, d[0]);
    tick(2);
    chk_word("raw tuning word", 48'h7e57_0bad_cafe, coreCtrl.tuneWord);
    reg_wr(`DMSEQ_REG_RAW, 32'h0);
    $display("test regs done");
  endtask

  task automatic test_tone();
    logic [15:0] p0, p1;
    set_pair(`DMSEQ_REG_TONE_LO, 48'h1234_5678_9abc);
    reg_wr(`DMSEQ_REG_MODE, 32'h0);
    tick(3);
    chk_word("tone word", 48'h1234_5678_9abc, coreCtrl.tuneWord);
    p0 = phaseOut;
    tick(1);
    p1 = phaseOut;
    chk_flag("phase advance", 1'b1, (p1 - p0) == 16'h1234 || (p1 - p0) == 16'h1235);
    clkEn <= 1'b0;
    tick(2);
    p0 = phaseOut;
    tick(3);
    chk_word("frozen phase", {32'h0, p0}, {32'h0, phaseOut});
    clkEn <= 1'b1;
    tick(1);
    chk_flag("trigger enable", 1'b1, triggerOutEn);
    reg_wr(`DMSEQ_REG_MODE, 32'h7);
    tick(3);
    chk_word("unused mode word", 48'h1234_5678_9abc, coreCtrl.tuneWord);
    $display("test tone done");
  endtask

  task automatic test_fsk();
    logic prev;
    set_pair(`DMSEQ_REG_F1_LO, F1);
    set_pair(`DMSEQ_REG_F2_LO, F2);
    keyCmd <= 2'h0;
    reg_wr(`DMSEQ_REG_MODE, 32'h1);
    key_case(2'h0, F1, 16'h0, 1'b0);
    key_case(2'h1, F2, 16'h0, 1'b0);
    key_case(2'h2, F2, 16'h0, 1'b0);
    keyCmd <= 2'h3;
    tick(2);
    prev = keySelectIn;
    for (int i = 0; i < 10; i++) begin
      tick(1);
      chk_word("toggled tuning word", prev ? F2 : F1, coreCtrl.tuneWord);
      prev = keySelectIn;
    end
    $display("test fsk done");
  endtask

  task automatic test_bpsk();
    reg_wr(`DMSEQ_REG_PHASE, 32'h4000_1000);
    keyCmd <= 2'h0;
    reg_wr(`DMSEQ_REG_MODE, 32'h4);
    key_case(2'h0, F1, 16'h1000, 1'b1);
    key_case(2'h1, F1, 16'h4000, 1'b1);
    key_case(2'h2, F1, 16'h4000, 1'b1);
    $display("test bpsk done");
  endtask

  task automatic test_ramp();
    set_pair(`DMSEQ_REG_F1_LO, RF1);
    set_pair(`DMSEQ_REG_F2_LO, RF1 + 48'h3 * RSTEP);
    set_pair(`DMSEQ_REG_STEP_LO, RSTEP);
    reg_wr(`DMSEQ_REG_DWELL, 32'h4);
    // deliberately not the aligned value: the ramp must not care
    reg_wr(`DMSEQ_REG_REPEAT, 32'h7);
    keyCmd <= 2'h0;
    reg_wr(`DMSEQ_REG_MODE, 32'h2);
    tick(3);
    chk_word("ramp start", RF1, coreCtrl.tuneWord);
    for (int i = 0; i < 20 && coreCtrl.tuneWord !== RF1 + RSTEP; i++) begin
      tick(1);
    end
    tick(2);
    for (int k = 1; k <= 8; k++) begin
      chk_word("ramp step", RF1 + RSTEP * tri_pos(k), coreCtrl.tuneWord);
      tick(5);
    end
    // aligned repeat: three steps of five cycles each way give a 30 cycle period
    reg_wr(`DMSEQ_REG_REPEAT, 32'he);
    for (int i = 0; i < 40 && triggerOutput !== 1'b1; i++) begin
      tick(1);
    end
    tick(1);
    chk_word("aligned trigger at ramp start", RF1, coreCtrl.tuneWord);
    $display("test ramp done");
  endtask

  task automatic test_chirp();
    logic prev;
    int hi;
    logic [47:0] mn, mx;
    set_pair(`DMSEQ_REG_F1_LO, CF1);
    set_pair(`DMSEQ_REG_STEP_LO, CSTEP);
    reg_wr(`DMSEQ_REG_DWELL, 32'h1);
    reg_wr(`DMSEQ_REG_REPEAT, 32'h9);
    keyCmd <= 2'h0;
    reg_wr(`DMSEQ_REG_MODE, 32'h3);
    prev = 1'b1;
    for (int i = 0; i < 60 && !(prev === 1'b0 && triggerOutput === 1'b1); i++) begin
      prev = triggerOutput;
      tick(1);
    end
    hi = 1;
    mn = '1;
    mx = '0;
    for (int k = 1; k <= 20; k++) begin
      prev = triggerOutput;
      tick(1);
      if (k < 20 && triggerOutput === 1'b1) hi++;
      if (coreCtrl.tuneWord < mn) mn = coreCtrl.tuneWord;
      if (coreCtrl.tuneWord > mx) mx = coreCtrl.tuneWord;
    end
    chk_word("trigger high cycles", 48'd8, 48'(hi));
    chk_flag("trigger low before next pulse", 1'b0, prev);
    chk_flag("next trigger pulse", 1'b1, triggerOutput);
    chk_word("chirp lowest", CF1, mn);
    chk_word("chirp highest", CF1 + 48'h9 * CSTEP, mx);
    $display("test chirp done");
  endtask

  initial begin
    reset_n = 1'b0;
    clkEn = 1'b1;
    regAddr = '0;
    regWrData = '0;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    keyCmd = 2'h2;
    repeat (8) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    test_regs();
    test_tone();
    test_fsk();
    test_bpsk();
    test_ramp();
    test_chirp();
    wrap_up();
  end

  // the whole sequence needs well under a thousand cycles
  initial begin
    #100000;
    failures++;
    $display("watchdog expired");
    wrap_up();
  end
endmodule
